// File: verilog/dvp_pkg.sv
// distance value processing constants, types and summary
// Summary of operation
// - averaging outputs floating mean of the latest N samples
// - averaging window length limited to 2 through 99 samples
// - step input ramps linearly to new value over N samples
// - exactly one output per input sample, filter or not
// - outlier mode collects a block, sorts it, drops both tails
// - outlier block size limited to 5 through 99 samples
// - coarse depth drops 12 percent per end, averages centre
// - medium depth averages roughly the central half
// - strong depth drops 36 percent per end, averages centre
// - falling gradient inverts the distance value
// - signed millimetre offset added to every filtered value
// - reference trim stores preset minus current measurement
// - negative corrected result reported as zero everywhere
// - language change latched, active only after restart
// - auto-off display switches off six minutes after button
// - off display shows no value, lights only for a minute after button or reset
// - on display stays full brightness, no dimming timer
package dvp_pkg;
  localparam int unsigned DVP_CLK_HZ      = 40_000_000;
  localparam int unsigned DVP_TICK_MS     = 1000;
  localparam int unsigned DVP_TICK_CYCLES = DVP_CLK_HZ / 1000 * DVP_TICK_MS;
  localparam logic [8:0]  DVP_FULL_S      = 9'h03c;
  localparam logic [8:0]  DVP_DIM_END_S   = 9'h168;
  localparam logic [8:0]  DVP_OFF_S       = 9'h168;
  localparam logic [8:0]  DVP_SECS_RST    = 9'h000;
  localparam int          DVP_DW          = 16;
  localparam int          DVP_FIFO_DEPTH  = 32;
  localparam int          DVP_HIST        = 99;
  localparam logic [6:0]  DVP_HIST_LAST   = 7'h62;
  localparam logic [6:0]  DVP_AVG_MIN     = 7'h02;
  localparam logic [6:0]  DVP_SPK_MIN     = 7'h05;
  localparam logic [6:0]  DVP_CNT_MAX     = 7'h63;
  localparam logic [6:0]  DVP_PCT_COARSE  = 7'h0c;
  localparam logic [6:0]  DVP_PCT_MEDIUM  = 7'h19;
  localparam logic [6:0]  DVP_PCT_STRONG  = 7'h24;
  localparam logic [23:0] DVP_DIV100_MUL  = 24'h000290;
  localparam int          DVP_DIV100_SH   = 16;
  localparam logic [4:0]  DVP_DIV_STEPS   = 5'h18;
  localparam logic [15:0] DVP_RANGE_MM    = 16'hffff;
  localparam logic [15:0] DVP_OFFSET_RST  = 16'h0000;

  typedef enum logic [1:0] {
    DVP_F_NONE  = 2'b00,
    DVP_F_AVG   = 2'b01,
    DVP_F_SPIKE = 2'b10
  } dvp_ftype_t;

  typedef enum logic [1:0] {
    DVP_D_COARSE = 2'b00,
    DVP_D_MEDIUM = 2'b01,
    DVP_D_STRONG = 2'b10
  } dvp_depth_t;

  typedef enum logic [1:0] {
    DVP_M_AUTO     = 2'b00,
    DVP_M_AUTO_OFF = 2'b01,
    DVP_M_OFF      = 2'b10,
    DVP_M_ON       = 2'b11
  } dvp_dmode_t;

  typedef enum logic [1:0] {
    DVP_B_FULL = 2'b00,
    DVP_B_DIM  = 2'b01,
    DVP_B_DARK = 2'b10,
    DVP_B_OFF  = 2'b11
  } dvp_bright_t;

  typedef enum logic {
    DVP_L_ENGLISH = 1'b0,
    DVP_L_GERMAN  = 1'b1
  } dvp_lang_t;

  typedef enum logic [2:0] {
    DVP_S_IDLE = 3'b000,
    DVP_S_INS  = 3'b001,
    DVP_S_SUM  = 3'b010,
    DVP_S_LOAD = 3'b011,
    DVP_S_DIV  = 3'b100,
    DVP_S_POST = 3'b101
  } dvp_state_t;

  typedef struct packed {
    dvp_ftype_t ftype;
    logic [6:0] avg_n;
    logic [6:0] spk_n;
    dvp_depth_t depth;
    logic       falling;
    dvp_dmode_t dmode;
  } dvp_cfg_t;
endpackage : dvp_pkg

// File: verilog/dvp_fifo.sv
// sample buffer between front end and filter engine
`timescale 1ns/1ps
module dvp_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input  logic         clk_sys,
  input  logic         reset,
  input  logic         in_valid,
  input  logic [W-1:0] in_data,
  output logic         in_ready,
  output logic         out_valid,
  output logic [W-1:0] out_data,
  input  logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  wire          full;
  wire          empty;
  wire          push;
  wire          pop;

  // extra pointer bit tells full from empty
  assign full      = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty     = (wp == rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end
endmodule : dvp_fifo

// File: verilog/dvp_core.sv
// distance filter, correction and display timing engine
`timescale 1ns/1ps
module dvp_core #(
  parameter int unsigned TICK_CYCLES = dvp_pkg::DVP_TICK_CYCLES
) (
  input  logic                clk_sys,
  input  logic                reset,
  input  logic                in_valid,
  input  logic [15:0]         in_distance,
  output logic                in_ready,
  input  dvp_pkg::dvp_cfg_t   cfg,
  input  logic [15:0]         offset_value,
  input  logic                offset_write,
  input  logic [15:0]         preset_value,
  input  logic                reference_trim_command,
  output logic                trim_busy,
  output logic [15:0]         offset_now,
  output logic                out_valid,
  output logic [15:0]         out_distance,
  output logic [15:0]         display_value,
  input  logic                button_pin,
  input  dvp_pkg::dvp_lang_t  language_sel,
  input  logic                restart,
  output dvp_pkg::dvp_lang_t  language_active,
  output dvp_pkg::dvp_bright_t display_bright,
  output logic                display_show
);
  import dvp_pkg::*;

  dvp_state_t  state;
  logic [15:0] cur, held, filt, last_meas, offset;
  logic [15:0] hist [DVP_HIST];
  logic [15:0] sorted [DVP_HIST];
  logic [6:0]  wr, fill, blk, ins_i, sum_i, drem, dden;
  logic [23:0] sum_avg, acc, dq;
  logic        have_held, have_meas, btn_s1, btn_s2, btn_s3;
  logic [4:0]  dcnt;
  dvp_cfg_t    cfg_prev;
  logic [25:0] tick_cnt;
  logic [8:0]  secs;
  dvp_lang_t   lang_pend;

  wire         f_valid, f_ready, changed, pop, ins_shift, dge, press, tick;
  wire         is_avg, next_show;
  wire [15:0]  f_data, old_val, grad, res;
  wire [6:0]   n_avg, n_spk, pct, trim, keep, last_i, old_idx, new_fill;
  wire [13:0]  prod;
  wire [23:0]  t24, new_sum;
  wire [7:0]   dsh;
  wire [17:0]  corr;
  dvp_bright_t next_bright;

  dvp_fifo #(
    .W (DVP_DW),
    .D (DVP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_data   (in_distance),
    .in_ready  (in_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // window lengths held inside their legal ranges
  assign n_avg = (cfg.avg_n < DVP_AVG_MIN) ? DVP_AVG_MIN :
                 (cfg.avg_n > DVP_CNT_MAX) ? DVP_CNT_MAX : cfg.avg_n;
  assign n_spk = (cfg.spk_n < DVP_SPK_MIN) ? DVP_SPK_MIN :
                 (cfg.spk_n > DVP_CNT_MAX) ? DVP_CNT_MAX : cfg.spk_n;
  assign changed = (cfg.ftype != cfg_prev.ftype) ||
                   (cfg.avg_n != cfg_prev.avg_n) ||
                   (cfg.spk_n != cfg_prev.spk_n);
  assign f_ready = (state == DVP_S_IDLE) && !changed;
  assign pop     = f_ready && f_valid;
  assign is_avg  = (cfg.ftype == DVP_F_AVG);

  // tail size per end: floor(n * pct / 100) by reciprocal multiply
  assign pct  = (cfg.depth == DVP_D_STRONG) ? DVP_PCT_STRONG :
                (cfg.depth == DVP_D_MEDIUM) ? DVP_PCT_MEDIUM :
                DVP_PCT_COARSE;
  assign prod   = 14'(n_spk * pct);
  assign t24    = 24'({10'h000, prod} * DVP_DIV100_MUL);
  assign trim   = t24[DVP_DIV100_SH+6:DVP_DIV100_SH];
  assign keep   = 7'(n_spk - {trim[5:0], 1'b0});
  assign last_i = 7'(n_spk - trim - 7'h01);

  // ring slot that drops out of the window
  assign old_idx  = (wr >= n_avg) ? 7'(wr - n_avg)
                                  : 7'(wr + DVP_CNT_MAX - n_avg);
  assign old_val  = (fill >= n_avg) ? hist[old_idx] : 16'h0000;
  assign new_sum  = 24'(sum_avg + {8'h00, f_data} - {8'h00, old_val});
  assign new_fill = (fill < n_avg) ? 7'(fill + 7'h01) : fill;

  assign ins_shift = (ins_i != 7'h00) && (sorted[ins_i - 7'h01] > cur);

  // restoring divider step
  assign dsh = {drem, dq[23]};
  assign dge = (dsh >= {1'b0, dden});

  assign grad = cfg.falling ? 16'(DVP_RANGE_MM - filt) : filt;
  assign corr = 18'($signed({2'b00, grad}) +
                    $signed({{2{offset[15]}}, offset}));
  assign res  = corr[17] ? 16'h0000 :
                corr[16] ? '1 : corr[15:0];

  always_ff @(posedge clk_sys) begin
    if (pop && is_avg) hist[wr] <= f_data;
  end

  always_ff @(posedge clk_sys) begin
    if (state == DVP_S_INS) begin
      if (ins_shift) sorted[ins_i] <= sorted[ins_i - 7'h01];
      else sorted[ins_i] <= cur;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state     <= DVP_S_IDLE;
      cur       <= 16'h0000;
      wr        <= 7'h00;
      fill      <= 7'h00;
      sum_avg   <= 24'h000000;
      blk       <= 7'h00;
      ins_i     <= 7'h00;
      sum_i     <= 7'h00;
      acc       <= 24'h000000;
      held      <= 16'h0000;
      have_held <= 1'b0;
      dq        <= 24'h000000;
      drem      <= 7'h00;
      dden      <= 7'h01;
      dcnt      <= 5'h00;
      filt      <= 16'h0000;
      cfg_prev  <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      case (state)
        DVP_S_IDLE: begin
          if (changed) begin
            // a new window or mode restarts history
            cfg_prev  <= cfg;
            fill      <= 7'h00;
            wr        <= 7'h00;
            sum_avg   <= 24'h000000;
            blk       <= 7'h00;
            have_held <= 1'b0;
          end else if (pop) begin
            cur <= f_data;
            case (cfg.ftype)
              DVP_F_AVG: begin
                sum_avg <= new_sum;
                fill    <= new_fill;
                wr      <= (wr == DVP_HIST_LAST) ? 7'h00 : 7'(wr + 7'h01);
                state   <= DVP_S_LOAD;
              end
              DVP_F_SPIKE: begin
                ins_i <= blk;
                state <= DVP_S_INS;
              end
              default: begin
                filt  <= f_data;
                state <= DVP_S_POST;
              end
            endcase
          end
        end
        DVP_S_INS: begin
          if (ins_shift) begin
            ins_i <= 7'(ins_i - 7'h01);
          end else if (7'(blk + 7'h01) == n_spk) begin
            blk   <= 7'(blk + 7'h01);
            sum_i <= trim;
            acc   <= 24'h000000;
            state <= DVP_S_SUM;
          end else begin
            // block not complete: repeat last block result, or pass the sample if none yet
            blk   <= 7'(blk + 7'h01);
            filt  <= have_held ? held : cur;
            state <= DVP_S_POST;
          end
        end
        DVP_S_SUM: begin
          acc   <= 24'(acc + {8'h00, sorted[sum_i]});
          sum_i <= 7'(sum_i + 7'h01);
          if (sum_i == last_i) state <= DVP_S_LOAD;
        end
        DVP_S_LOAD: begin
          dq    <= is_avg ? sum_avg : acc;
          dden  <= is_avg ? fill : keep;
          drem  <= 7'h00;
          dcnt  <= 5'h00;
          state <= DVP_S_DIV;
        end
        DVP_S_DIV: begin
          dq   <= {dq[22:0], dge};
          drem <= dge ? 7'(dsh - {1'b0, dden}) : dsh[6:0];
          dcnt <= 5'(dcnt + 5'h01);
          if (dcnt == 5'(DVP_DIV_STEPS - 5'h01)) begin
            filt  <= {dq[14:0], dge};
            state <= DVP_S_POST;
            if (!is_avg) begin
              held      <= {dq[14:0], dge};
              have_held <= 1'b1;
              blk       <= 7'h00;
            end
          end
        end
        DVP_S_POST: begin
          out_valid <= 1'b1;
          state     <= DVP_S_IDLE;
        end
        default: state <= DVP_S_IDLE;
      endcase
    end
  end

  // corrected value goes to interface and display alike
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_distance  <= 16'h0000;
      display_value <= 16'h0000;
      last_meas     <= 16'h0000;
      have_meas     <= 1'b0;
    end else if (state == DVP_S_POST) begin
      out_distance  <= res;
      display_value <= res;
      last_meas     <= grad;
      have_meas     <= 1'b1;
    end
  end

  // reference trim: one shot per request, waits for a measurement
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      offset    <= DVP_OFFSET_RST;
      trim_busy <= 1'b0;
    end else begin
      if (trim_busy && have_meas) begin
        offset    <= 16'(preset_value - last_meas);
        // a fresh request in the apply cycle is kept, not lost
        trim_busy <= reference_trim_command;
      end else begin
        if (offset_write) offset <= offset_value;
        if (reference_trim_command) trim_busy <= 1'b1;
      end
    end
  end
  assign offset_now = offset;

  // language takes effect only at restart
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lang_pend       <= DVP_L_ENGLISH;
      language_active <= DVP_L_ENGLISH;
    end else begin
      lang_pend <= language_sel;
      if (restart) language_active <= lang_pend;
    end
  end

  // button pin synchroniser and second timer
  assign press = btn_s2 && !btn_s3;
  assign tick  = (tick_cnt == 26'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      btn_s1   <= 1'b0;
      btn_s2   <= 1'b0;
      btn_s3   <= 1'b0;
      tick_cnt <= 26'h0000000;
      secs     <= DVP_SECS_RST;
    end else begin
      btn_s1 <= button_pin;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
      if (press) begin
        tick_cnt <= 26'h0000000;
        secs     <= DVP_SECS_RST;
      end else begin
        tick_cnt <= tick ? 26'h0000000 : 26'(tick_cnt + 26'h0000001);
        if (tick && secs != DVP_DIM_END_S) secs <= 9'(secs + 9'h001);
      end
    end
  end

  assign next_bright =
    (cfg.dmode == DVP_M_ON) ? DVP_B_FULL :
    (cfg.dmode == DVP_M_AUTO) ?
      ((secs < DVP_FULL_S) ? DVP_B_FULL :
       (secs < DVP_DIM_END_S) ? DVP_B_DIM : DVP_B_DARK) :
    (cfg.dmode == DVP_M_AUTO_OFF) ?
      ((secs < DVP_OFF_S) ? DVP_B_FULL : DVP_B_OFF) :
    ((secs < DVP_FULL_S) ? DVP_B_FULL : DVP_B_OFF);
  assign next_show =
    (cfg.dmode == DVP_M_OFF) ? 1'b0 :
    (cfg.dmode == DVP_M_AUTO_OFF) ? (secs < DVP_OFF_S) : 1'b1;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      display_bright <= DVP_B_FULL;
      display_show   <= 1'b1;
    end else begin
      display_bright <= next_bright;
      display_show   <= next_show;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  one_out_a: assert property (pop |=> !f_ready until out_valid)
    else $error("second sample taken before output");
  out_bound_a: assert property (pop |-> ##[2:300] out_valid)
    else $error("no output for taken sample");
  avg_range_a: assert property (n_avg >= 7'h02 && n_avg <= 7'h63)
    else $error("averaging window out of range");
  spk_range_a: assert property (n_spk >= 7'h05 && n_spk <= 7'h63)
    else $error("block size out of range");
  fill_cap_a: assert property (!changed |-> fill <= n_avg)
    else $error("window holds more than n samples");
  coarse_trim_a: assert property (cfg.depth == DVP_D_COARSE |->
      int'(trim) == int'(n_spk) * 12 / 100)
    else $error("coarse tail size wrong");
  medium_trim_a: assert property (cfg.depth == DVP_D_MEDIUM |->
      int'(trim) == int'(n_spk) * 25 / 100)
    else $error("medium tail size wrong");
  strong_trim_a: assert property (cfg.depth == DVP_D_STRONG |->
      int'(trim) == int'(n_spk) * 36 / 100)
    else $error("strong tail size wrong");
  sort_order_a: assert property (state == DVP_S_SUM && sum_i < last_i
      |-> sorted[sum_i] <= sorted[7'(sum_i + 7'h01)])
    else $error("block not sorted");
  grad_inv_a: assert property (state == DVP_S_POST && cfg.falling
      |=> last_meas == 16'(DVP_RANGE_MM - $past(filt)))
    else $error("falling gradient not inverted");
  offset_add_a: assert property (state == DVP_S_POST && !cfg.falling &&
      $signed({2'b00, filt}) + $signed({{2{offset[15]}}, offset}) >= 0 &&
      $signed({2'b00, filt}) + $signed({{2{offset[15]}}, offset}) < 65536
      |=> out_distance == 16'($past(filt) + $past(offset)))
    else $error("offset not applied");
  clamp_zero_a: assert property (state == DVP_S_POST && corr[17]
      |=> out_distance == 16'h0000 && display_value == 16'h0000)
    else $error("negative result not clamped");
  trim_once_a: assert property (trim_busy && have_meas |=>
      trim_busy == $past(reference_trim_command) &&
      offset_now == 16'($past(preset_value) - $past(last_meas)))
    else $error("reference trim not applied once");
  lang_hold_a: assert property (!restart |=> $stable(language_active))
    else $error("language changed without restart");
  disp_on_a: assert property (cfg.dmode == DVP_M_ON ##1
      cfg.dmode == DVP_M_ON |-> display_bright == DVP_B_FULL)
    else $error("on mode dimmed");
  disp_off_a: assert property (cfg.dmode == DVP_M_OFF ##1
      cfg.dmode == DVP_M_OFF |-> !display_show)
    else $error("off mode shows value");
  auto_full_a: assert property (cfg.dmode == DVP_M_AUTO && press
      |-> ##2 display_bright == DVP_B_FULL)
    else $error("auto mode not full after press");

  avg_out_c: cover property (is_avg && state == DVP_S_DIV ##[1:30] out_valid);
  blk_done_c: cover property (state == DVP_S_SUM ##[1:130] out_valid);
  trim_done_c: cover property (trim_busy ##1 !trim_busy);
  clamp_c: cover property (state == DVP_S_POST && corr[17]);
endmodule : dvp_core

// File: test/dvp_front_end.sv
// ranging front end model offering raw distance samples
`timescale 1ns/1ps
module dvp_front_end (
  input  wire logic        clk_sys,
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic [15:0]      in_distance
);
  initial begin
    in_valid = 1'b0;
    in_distance = 16'h0000;
  end

  // offer one sample, hold it until the buffer takes it
  task automatic send(input logic [15:0] v);
    @(posedge clk_sys);
    in_valid <= 1'b1;
    in_distance <= v;
    do @(posedge clk_sys); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    // released bus shows no stale value
    in_distance <= ~v;
  endtask : send
endmodule : dvp_front_end

// File: test/distance_value_processing_tb.sv
// self-checking bench for the distance processing core
`timescale 1ns/1ps
module distance_value_processing_tb;
  import dvp_pkg::*;
  localparam int TK = 4;
  logic        clk_sys, reset, in_valid, in_ready, offset_write;
  logic        reference_trim_command, trim_busy, out_valid;
  logic        button_pin, restart, display_show;
  logic [15:0] in_distance, offset_value, preset_value, offset_now;
  logic [15:0] out_distance, display_value;
  dvp_cfg_t    cfg;
  dvp_lang_t   language_sel, language_active;
  dvp_bright_t display_bright;
  int          fail_count = 0;
  int          compares = 0;
  logic [15:0] got[$];
  logic [15:0] dsp[$];

  dvp_core #(.TICK_CYCLES(TK)) u_dvp_core (
    .clk_sys(clk_sys), .reset(reset), .in_valid(in_valid),
    .in_distance(in_distance), .in_ready(in_ready), .cfg(cfg),
    .offset_value(offset_value), .offset_write(offset_write),
    .preset_value(preset_value),
    .reference_trim_command(reference_trim_command),
    .trim_busy(trim_busy), .offset_now(offset_now),
    .out_valid(out_valid), .out_distance(out_distance),
    .display_value(display_value), .button_pin(button_pin),
    .language_sel(language_sel), .restart(restart),
    .language_active(language_active),
    .display_bright(display_bright), .display_show(display_show)
  );

  dvp_front_end u_dvp_front_end (
    .clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
    .in_distance(in_distance)
  );

  always @(posedge clk_sys) begin
    if (out_valid === 1'b1) begin
      got.push_back(out_distance);
      dsp.push_back(display_value);
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // feed samples, wait for the outputs, compare all or only the last
  task automatic run(input logic [15:0] s[$], input logic [15:0] e[$],
                     input bit last);
    int n;
    got = {};
    dsp = {};
    foreach (s[i]) u_dvp_front_end.send(s[i]);
    n = 0;
    while (got.size() < s.size() && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check(16'(got.size()), 16'(s.size()));
    if (last) begin
      check(got[$], e[0]);
    end else begin
      foreach (e[i]) check(got[i], e[i]);
      foreach (e[i]) check(dsp[i], e[i]);
    end
    tick(4);
  endtask : run

  task automatic set_off(input logic [15:0] v);
    offset_value <= v;
    offset_write <= 1'b1;
    @(posedge clk_sys);
    offset_write <= 1'b0;
    tick(2);
    check(offset_now, v);
  endtask : set_off

  task automatic t_plain();
    set_off(16'hff9c);
    run({16'h05dc, 16'h0032}, {16'h0578, 16'h0000}, 0);
    set_off(16'h0000);
  endtask : t_plain

  task automatic t_falling();
    cfg.falling <= 1'b1;
    tick(4);
    run({16'h0064}, {16'hff9b}, 0);
    cfg.falling <= 1'b0;
  endtask : t_falling

  task automatic t_avg();
    cfg.ftype <= DVP_F_AVG;
    cfg.avg_n <= 7'h04;
    tick(4);
    run({16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0190, 16'h0190,
         16'h0190, 16'h0190}, {16'h0000, 16'h0000, 16'h0000, 16'h0000,
         16'h0064, 16'h00c8, 16'h012c, 16'h0190}, 0);
    cfg.avg_n <= 7'h02;
    tick(4);
    run({16'h000a, 16'h0014, 16'h001e},
        {16'h000a, 16'h000f, 16'h0019}, 0);
    cfg.avg_n <= 7'h00;
    tick(4);
    run({16'h000a, 16'h0014, 16'h001e},
        {16'h000a, 16'h000f, 16'h0019}, 0);
  endtask : t_avg

  task automatic t_spike();
    logic [15:0] blk[$];
    logic [15:0] res[3];
    blk = {16'h0200, 16'h0001, 16'h0100, 16'h0002, 16'h0080,
           16'h0004, 16'h0040, 16'h0008, 16'h0020, 16'h0010};
    res = '{16'h003f, 16'h002a, 16'h001e};
    cfg.ftype <= DVP_F_SPIKE;
    cfg.spk_n <= 7'h0a;
    for (int d = 0; d < 3; d++) begin
      cfg.depth <= dvp_depth_t'(d);
      tick(4);
      run(blk, {res[d]}, 1);
    end
    cfg.spk_n <= 7'h03;
    tick(4);
    run({16'h0064, 16'h0001, 16'h0002, 16'h0003, 16'h0004},
        {16'h0003}, 1);
  endtask : t_spike

  task automatic t_trim();
    cfg.ftype <= DVP_F_NONE;
    tick(4);
    run({16'h012c}, {16'h012c}, 0);
    preset_value <= 16'h015e;
    reference_trim_command <= 1'b1;
    @(posedge clk_sys);
    reference_trim_command <= 1'b0;
    #1 check({15'h0000, trim_busy}, 16'h0001);
    @(posedge clk_sys);
    #1 check({15'h0000, trim_busy}, 16'h0000);
    check(offset_now, 16'h0032);
    tick(3);
    check({15'h0000, trim_busy}, 16'h0000);
    run({16'h0190}, {16'h01c2}, 0);
  endtask : t_trim

  task automatic t_lang();
    language_sel <= DVP_L_GERMAN;
    tick(4);
    check({15'h0000, language_active}, 16'h0000);
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
    tick(2);
    check({15'h0000, language_active}, 16'h0001);
    language_sel <= DVP_L_ENGLISH;
    tick(4);
    check({15'h0000, language_active}, 16'h0001);
  endtask : t_lang

  task automatic press(input dvp_dmode_t m);
    cfg.dmode <= m;
    button_pin <= 1'b1;
    tick(3);
    button_pin <= 1'b0;
  endtask : press

  // wait some seconds, then compare brightness and visibility
  task automatic dat(input int secs, input dvp_bright_t eb,
                     input logic es);
    tick(secs * TK);
    check({14'h0000, display_bright}, {14'h0000, eb});
    check({15'h0000, display_show}, {15'h0000, es});
  endtask : dat

  task automatic t_display();
    press(DVP_M_AUTO);
    tick(30 * TK);
    check({14'h0000, display_bright}, 16'h0000);
    tick(170 * TK);
    check({14'h0000, display_bright}, 16'h0001);
    tick(200 * TK);
    check({14'h0000, display_bright}, 16'h0002);
    press(DVP_M_AUTO_OFF);
    dat(300, DVP_B_FULL, 1'b1);
    dat(100, DVP_B_OFF, 1'b0);
    press(DVP_M_OFF);
    dat(30, DVP_B_FULL, 1'b0);
    dat(100, DVP_B_OFF, 1'b0);
    cfg.dmode <= DVP_M_ON;
    dat(400, DVP_B_FULL, 1'b1);
  endtask : t_display

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    reset = 1'b1;
    cfg = '0;
    offset_value = 16'h0000;
    offset_write = 1'b0;
    preset_value = 16'h0000;
    reference_trim_command = 1'b0;
    button_pin = 1'b0;
    language_sel = DVP_L_ENGLISH;
    restart = 1'b0;
    tick(16);
    reset <= 1'b0;
    tick(2);
    t_plain();
    t_falling();
    t_avg();
    t_spike();
    t_trim();
    t_lang();
    t_display();
    report_and_stop();
  end

  // hang guard, far beyond the expected run length
  initial begin
    tick(40000);
    fail_count++;
    report_and_stop();
  end
endmodule : distance_value_processing_tb
